// *** hw/anps_defines.vh ***
`ifndef ANPS_DEFINES_VH
`define ANPS_DEFINES_VH

// Register indices as printed; byte address is four times the index.
`define ANPS_IDX_PARTNER      4'h5
`define ANPS_IDX_EXPANSION    4'h6
`define ANPS_IDX_IRQ_STATUS   4'h8
`define ANPS_IDX_IRQ_MASK     4'h9
`define ANPS_IDX_CONTROL      4'ha
`define ANPS_ADDR_LSB         2
`define ANPS_ADDR_MSB         5

// Partner ability register field positions.
`define ANPS_PA_NEXT_PAGE     15
`define ANPS_PA_ACK           14
`define ANPS_PA_REMOTE_FAULT  13
`define ANPS_PA_FLOW_CTRL     10
`define ANPS_PA_TECH_MSB      9
`define ANPS_PA_TECH_LSB      5
`define ANPS_PA_SEL_MSB       4
`define ANPS_PA_SEL_LSB       0
`define ANPS_PA_RESET         16'h0000
`define ANPS_PA_LIVE_MASK     16'he7ff

// Expansion register field positions.
`define ANPS_EX_PD_FAULT      4
`define ANPS_EX_PARTNER_NP    3
`define ANPS_EX_LOCAL_NP      2
`define ANPS_EX_PAGE_RX       1
`define ANPS_EX_PARTNER_AN    0
`define ANPS_EX_RESET         5'h00

// Interrupt status layout.
`define ANPS_IRQ_PAGE         0
`define ANPS_IRQ_FAULT        1
`define ANPS_IRQ_WIDTH        2
`define ANPS_IRQ_RESET        2'h0

// Control register: bit 0 enables capture of partner pages.
`define ANPS_CTL_CAPTURE      0
`define ANPS_CTL_RESET        1'h1

`endif

// *** hw/anps_sync.v ***
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for one level from outside the clock domain.
module anps_sync (
    input  wire clock,
    input  wire rst_n,
    input  wire din,
    output wire dout
);
    reg stage1_reg;
    reg stage2_reg;

    // Only the second stage is read by other logic.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
        end
    end

    assign dout = stage2_reg;
endmodule

`default_nettype wire

// *** hw/anps_irq.v ***
`timescale 1ns/100ps
`default_nettype none
`include "anps_defines.vh"

// Sticky event bits, write-one-to-clear, masked onto one level output.
module anps_irq (
    input  wire                        clock,
    input  wire                        rst_n,
    input  wire [`ANPS_IRQ_WIDTH-1:0]  event_in,
    input  wire [`ANPS_IRQ_WIDTH-1:0]  clear_in,
    input  wire                        mask_we,
    input  wire [`ANPS_IRQ_WIDTH-1:0]  mask_wdata,
    output wire [`ANPS_IRQ_WIDTH-1:0]  status,
    output wire [`ANPS_IRQ_WIDTH-1:0]  mask,
    output wire                        irq
);
    reg [`ANPS_IRQ_WIDTH-1:0] status_reg;
    reg [`ANPS_IRQ_WIDTH-1:0] mask_reg;
    reg                       irq_reg;

    // A new event wins over a clear in the same cycle.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= `ANPS_IRQ_RESET;
            mask_reg   <= `ANPS_IRQ_RESET;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~clear_in) | event_in;
            if (mask_we) begin
                mask_reg <= mask_wdata;
            end
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign status = status_reg;
    assign mask   = mask_reg;
    assign irq    = irq_reg;
endmodule

`default_nettype wire

// *** hw/anps_regs.v ***
`timescale 1ns/100ps
`default_nettype none
`include "anps_defines.vh"

// Function
// [R1] Register 5 is loaded with the partner's advertised word and is read-only.
// [R2] Bit 15 of register 5 shows the partner's next page flag, reset 0.
// [R3] Bit 14 of register 5 comes only from the received acknowledge bit.
// [R4] Bit 13 of register 5 shows the partner's remote fault flag.
// [R5] Reserved bits 5.12-5.11 and 6.15-6.5 read zero and ignore writes.
// [R6] Bit 10 of register 5 shows the partner's flow control ability.
// [R7] Bits 9 to 5 of register 5 show T4, TX full, TX half, 10 full, 10 half.
// [R8] Bits 4 to 0 of register 5 hold the received selector, reset zero.
// [R9] Bit 4 of register 6 latches high on a parallel detection fault.
// [R10] Bit 3 of register 6 shows that the partner is next-page capable.
// [R11] Bit 2 of register 6 is tied to 0 since there is no local next page.
// [R12] Bit 1 of register 6 latches on a new page and clears on a read.
// [R13] Bit 0 of register 6 shows that the partner can auto-negotiate.
// [R14] The fault bit clears on a read of register 6 unless still present.
module anps_regs (
    input  wire        clock,
    input  wire        rst_n,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    // From the negotiation state machine, same clock.
    input  wire        page_valid,
    input  wire [15:0] page_word,
    input  wire        partner_an_capable,
    // Fault level from the parallel detection path, asynchronous.
    input  wire        pd_fault_async,
    // Interrupt output.
    output wire        irq
);
    reg  [15:0]                partner_reg;
    reg  [15:0]                partner_next;
    reg                        pd_fault_reg;
    reg                        pd_fault_next;
    reg                        page_rx_reg;
    reg                        page_rx_next;
    reg                        partner_np_reg;
    reg                        partner_an_reg;
    reg                        capture_reg;
    reg  [31:0]                rdata_reg;
    reg  [31:0]                rdata_next;
    reg                        err_reg;
    reg                        err_next;
    wire                       pd_fault_sync;
    wire                       setup;
    wire                       access;
    wire                       exp_read;
    wire                       page_take;
    wire [3:0]                 index;
    wire [15:0]                exp_word;
    wire [`ANPS_IRQ_WIDTH-1:0] irq_status;
    wire [`ANPS_IRQ_WIDTH-1:0] irq_mask;
    wire [`ANPS_IRQ_WIDTH-1:0] irq_event;
    wire [`ANPS_IRQ_WIDTH-1:0] irq_clear;

    // Tells whether an address decodes to one of the mapped registers.
    function mapped;
        input [3:0] idx;
        begin
            mapped = (idx == `ANPS_IDX_PARTNER)
                  || (idx == `ANPS_IDX_EXPANSION)
                  || (idx == `ANPS_IDX_IRQ_STATUS)
                  || (idx == `ANPS_IDX_IRQ_MASK)
                  || (idx == `ANPS_IDX_CONTROL);
        end
    endfunction

    // Fault level is from another domain and is synchronised first.
    anps_sync u_fault_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (pd_fault_async),
        .dout  (pd_fault_sync)
    );

    // Bus decode; every access completes in its first access cycle.
    assign index    = paddr[`ANPS_ADDR_MSB:`ANPS_ADDR_LSB];
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign exp_read = setup && !pwrite && (index == `ANPS_IDX_EXPANSION)
                   && (paddr[31:6] == 26'h0000000)
                   && (paddr[1:0] == 2'h0);
    assign page_take = page_valid && capture_reg;

    // Expansion word; reserved high bits and local next page are zero.
    assign exp_word = {11'h000,
                       pd_fault_reg,          // see [R9]
                       partner_np_reg,        // see [R10]
                       1'b0,                  // see [R11]
                       page_rx_reg,           // see [R12]
                       partner_an_reg};       // see [R13] see [R5]

    // Next partner word: a new page replaces the whole word.
    always @* begin
        partner_next = partner_reg;
        if (page_take) begin
            // Reserved bits forced to zero, all others from the page.
            partner_next = page_word & `ANPS_PA_LIVE_MASK; // see [R1] see [R5]
        end
    end

    // Latched flags; the read that samples them clears them, and a new
    // event in the same cycle keeps the flag set.
    always @* begin
        page_rx_next  = page_rx_reg;
        pd_fault_next = pd_fault_reg;
        if (exp_read) begin
            page_rx_next  = 1'b0;             // see [R12]
            pd_fault_next = 1'b0;             // see [R14]
        end
        if (page_take) begin
            page_rx_next = 1'b1;              // see [R12]
        end
        if (pd_fault_sync) begin
            pd_fault_next = 1'b1;             // see [R9] see [R14]
        end
    end

    // Register state for the captured page and the latched flags.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            partner_reg    <= `ANPS_PA_RESET;   // see [R2] see [R8]
            pd_fault_reg   <= 1'b0;
            page_rx_reg    <= 1'b0;
            partner_np_reg <= 1'b0;
            partner_an_reg <= 1'b0;
        end else begin
            partner_reg    <= partner_next;
            pd_fault_reg   <= pd_fault_next;
            page_rx_reg    <= page_rx_next;
            // Partner next-page ability follows its received next page bit.
            partner_np_reg <= partner_next[`ANPS_PA_NEXT_PAGE]; // see [R10]
            partner_an_reg <= partner_an_capable;  // see [R13]
        end
    end

    // Read data is sampled in the setup cycle so the latched flags are
    // shown as they were before the clearing read.
    always @* begin
        rdata_next = rdata_reg;
        err_next   = err_reg;
        if (setup) begin
            rdata_next = 32'h00000000;
            err_next   = !mapped(index) || (paddr[31:6] != 26'h0000000)
                      || (paddr[1:0] != 2'h0);
            if (!pwrite && !err_next) begin
                case (index)
                    `ANPS_IDX_PARTNER: begin
                        // Next page, ack, fault, flow, techs, selector.
                        rdata_next = {16'h0000, partner_reg}; // see [R2]
                        // see [R3] see [R4] see [R6] see [R7] see [R8]
                    end
                    `ANPS_IDX_EXPANSION: begin
                        rdata_next = {16'h0000, exp_word};
                    end
                    `ANPS_IDX_IRQ_STATUS: begin
                        rdata_next = {30'h00000000, irq_status};
                    end
                    `ANPS_IDX_IRQ_MASK: begin
                        rdata_next = {30'h00000000, irq_mask};
                    end
                    `ANPS_IDX_CONTROL: begin
                        rdata_next = {31'h00000000, capture_reg};
                    end
                    default: begin
                        rdata_next = 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Bus state and the writable control bit; writes to register 5 and
    // register 6 are accepted and dropped.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg   <= 32'h00000000;
            err_reg     <= 1'b0;
            capture_reg <= `ANPS_CTL_RESET;
        end else begin
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
            if (access && pwrite && !err_reg
                && index == `ANPS_IDX_CONTROL) begin
                capture_reg <= pwdata[`ANPS_CTL_CAPTURE];
            end
        end
    end

    // Write-one-to-clear of interrupt status, only on a completed write.
    assign irq_clear = (access && pwrite && !err_reg
                        && index == `ANPS_IDX_IRQ_STATUS)
                     ? pwdata[`ANPS_IRQ_WIDTH-1:0]
                     : {`ANPS_IRQ_WIDTH{1'b0}};
    assign irq_event = {pd_fault_sync & ~pd_fault_reg, page_take};

    anps_irq u_irq (
        .clock      (clock),
        .rst_n      (rst_n),
        .event_in   (irq_event),
        .clear_in   (irq_clear),
        .mask_we    (access && pwrite && !err_reg
                     && index == `ANPS_IDX_IRQ_MASK),
        .mask_wdata (pwdata[`ANPS_IRQ_WIDTH-1:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // Zero wait states: ready whenever the access phase is present.
    assign pready  = 1'b1;
    assign pslverr = access && err_reg;
    assign prdata  = rdata_reg;
endmodule

`default_nettype wire

// *** verification/anps_regs_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches the register block from its ports.
module anps_regs_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        page_valid,
    input wire logic [15:0] page_word,
    input wire logic        partner_an_capable,
    input wire logic        pd_fault_async,
    input wire logic        irq
);
    logic        cap_reg;
    logic        msk_reg;
    logic        pg_reg;
    logic [15:0] pa_reg;
    wire setup = psel && !penable && !pwrite;
    wire wr_acc = psel && penable && pwrite;
    wire rd6 = setup && paddr == 32'h18;
    wire take = page_valid && cap_reg;
    wire pa_np = pa_reg[15];
    wire good = paddr[31:6] == 26'h0 && paddr[1:0] == 2'h0 &&
        (paddr[5:2] inside {4'h5, 4'h6, 4'h8, 4'h9, 4'ha});
    // Shadow of capture enable, mask, page flag and captured word.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap_reg <= 1'b1;
            msk_reg <= 1'b0;
            pg_reg <= 1'b0;
            pa_reg <= 16'h0000;
        end else begin
            if (wr_acc && paddr == 32'h28) cap_reg <= pwdata[0];
            if (wr_acc && paddr == 32'h24) msk_reg <= pwdata[0];
            if (take) pa_reg <= page_word & 16'he7ff;
            if (take) pg_reg <= 1'b1;
            else if (rd6) pg_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_partner_load: assert property (
        setup && paddr == 32'h14 |=> prdata == {16'h0, $past(pa_reg)})
        else $error("partner word mismatch");
    a_exp_reserved: assert property (
        psel && penable && paddr == 32'h18 |-> prdata[31:5] == 27'h0
        && !prdata[2]) else $error("expansion reserved bit set");
    a_page_flag: assert property (
        rd6 |=> prdata[1] == $past(pg_reg)) else $error("page flag wrong");
    a_partner_np: assert property (
        rd6 |=> prdata[3] == $past(pa_np)) else $error("np capable wrong");
    a_an_capable: assert property (
        rd6 |=> prdata[0] == $past(partner_an_capable, 2))
        else $error("an capable wrong");
    a_fault_latch: assert property (
        pd_fault_async [*5] ##0 rd6 |=> prdata[4])
        else $error("fault not latched");
    a_bad_addr: assert property (psel && penable && !good |->
        pslverr && prdata == 32'h0) else $error("bad address accepted");
    a_irq_page: assert property (take && msk_reg |-> ##2 irq)
        else $error("irq missing after page");
    cover property (take);
    cover property (rd6 && pg_reg);
    cover property (irq);
endmodule
bind anps_regs anps_regs_chk i_anps_regs_chk (.clock, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .page_valid, .page_word, .partner_an_capable, .pd_fault_async, .irq);
`default_nettype wire

// *** verification/anps_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
// Remote partner: hands over received code words and line levels.
module anps_partner (
    input  wire logic        clock,
    output var  logic        page_valid,
    output var  logic [15:0] page_word,
    output var  logic        partner_an_capable,
    output var  logic        pd_fault_async
);
    // Quiet levels at time zero.
    initial begin
        page_valid = 1'b0;
        page_word = 16'hffff;
        partner_an_capable = 1'b0;
        pd_fault_async = 1'b0;
    end
    // One page; the acknowledge bit travels only inside the word.
    task send(input logic [15:0] w);
        begin
            page_valid <= 1'b1;
            page_word <= w;
            @(posedge clock);
            page_valid <= 1'b0;
            page_word <= ~w;
        end
    endtask
    // Sets the ability and fault levels.
    task levels(input logic an, input logic flt);
        begin
            partner_an_capable <= an;
            pd_fault_async <= flt;
        end
    endtask
endmodule
`default_nettype wire

// *** verification/test_anps_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_anps_regs;
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    wire         pready;
    wire         pslverr;
    wire  [31:0] prdata;
    wire         pv;
    wire  [15:0] pw;
    wire         an;
    wire         flt;
    wire         irq;
    int          n_fail;
    int          checks_done;
    logic [15:0] words [9];
    anps_regs i_anps_regs (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .page_valid(pv), .page_word(pw), .partner_an_capable(an),
        .pd_fault_async(flt), .irq(irq));
    anps_partner i_anps_partner (.clock(clock), .page_valid(pv),
        .page_word(pw), .partner_an_capable(an), .pd_fault_async(flt));
    // Free-running clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Prints the counts and the verdict, then stops.
    task give_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // One APB transfer followed by one idle cycle.
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
              output logic [31:0] d, output logic e);
        int n;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= wd;
            @(posedge clock);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (pready !== 1'b1 && n < 50);
            if (pready !== 1'b1) begin
                n_fail++;
                give_verdict();
            end else begin
                d = prdata;
                e = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                @(posedge clock);
            end
        end
    endtask
    // Reads a register and compares data and error flag.
    task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] d;
        logic        e;
        begin
            xfer(1'b0, a, 32'h0, d, e);
            `CHK(d, x)
            `CHK(e, xe)
        end
    endtask
    // Writes a register that must accept the access.
    task wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        begin
            xfer(1'b1, a, v, d, e);
            `CHK(e, 1'b0)
        end
    endtask
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        n_fail = 0;
        checks_done = 0;
        words = '{16'h2000, 16'h0400, 16'h0200, 16'h0100, 16'h0080,
                  16'h0040, 16'h0020, 16'h001f, 16'h1800};
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(32'h14, 32'h0, 1'b0);
        rd(32'h18, 32'h0, 1'b0);
        i_anps_partner.levels(1'b1, 1'b0);
        i_anps_partner.send(16'hffff);
        rd(32'h14, 32'he7ff, 1'b0);
        rd(32'h18, 32'hb, 1'b0);
        rd(32'h18, 32'h9, 1'b0);
        rd(32'h20, 32'h1, 1'b0);
        `CHK(irq, 1'b0)
        wr(32'h24, 32'h1);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b1)
        wr(32'h20, 32'h1);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        wr(32'h24, 32'h3);
        wr(32'h14, 32'hffffffff);
        wr(32'h18, 32'hffffffff);
        rd(32'h14, 32'he7ff, 1'b0);
        rd(32'h18, 32'h9, 1'b0);
        wr(32'h28, 32'h0);
        i_anps_partner.send(16'h4001);
        rd(32'h14, 32'he7ff, 1'b0);
        wr(32'h28, 32'h1);
        i_anps_partner.send(16'h4001);
        rd(32'h14, 32'h4001, 1'b0);
        rd(32'h18, 32'h3, 1'b0);
        foreach (words[i]) begin
            i_anps_partner.send(words[i]);
            rd(32'h14, 32'(words[i] & 16'he7ff), 1'b0);
        end
        rd(32'h18, 32'h3, 1'b0);
        i_anps_partner.levels(1'b1, 1'b1);
        repeat (8) @(posedge clock);
        rd(32'h18, 32'h11, 1'b0);
        rd(32'h18, 32'h11, 1'b0);
        i_anps_partner.levels(1'b1, 1'b0);
        repeat (8) @(posedge clock);
        rd(32'h18, 32'h11, 1'b0);
        rd(32'h18, 32'h1, 1'b0);
        rd(32'h20, 32'h3, 1'b0);
        wr(32'h20, 32'h3);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        rd(32'h1c, 32'h0, 1'b1);
        rd(32'h15, 32'h0, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
